/* rtl/ralc_pkg.sv */
// package: offsets, field positions and reset values of the channel registers
package ralc_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_FEEDBACK_MERIT_SELECT     = 8'h2c;
  localparam logic [7:0] ADDR_DRIVER_SWING              = 8'h2d;
  localparam logic [7:0] ADDR_RATE_LOCK_CONTROL         = 8'h2f;
  localparam logic [7:0] ADDR_EYE_INTERRUPT_STATUS      = 8'h30;
  localparam logic [7:0] ADDR_ADAPTATION_MODE_SELECT    = 8'h31;
  localparam logic [7:0] ADDR_EYE_INTERRUPT_THRESHOLD   = 8'h32;
  localparam logic [7:0] ADDR_HANDOFF_EYE_THRESHOLD     = 8'h33;
  localparam logic [7:0] ADDR_UPPER_TAP_LIMIT           = 8'h34;
  localparam logic [7:0] ADDR_FIRST_TAP_LIMIT           = 8'h35;
  localparam logic [7:0] ADDR_REFCLK_INTERRUPT_CONTROL  = 8'h36;
  localparam logic [7:0] ADDR_LINEAR_EQ_START_INDEX     = 8'h39;
  localparam logic [7:0] ADDR_LOW_RATE_FIXED_BOOST      = 8'h3a;
  localparam logic [7:0] ADDR_EYE_LOCK_MONITOR_ENABLE   = 8'h3e;
  localparam logic [7:0] ADDR_EYE_LOCK_THRESHOLD        = 8'h6a;
  localparam logic [7:0] ADDR_MERIT_TERM_A              = 8'h6b;
  localparam logic [7:0] ADDR_MERIT_TERM_B              = 8'h6c;
  localparam logic [7:0] ADDR_MERIT_TERM_C              = 8'h6d;
  localparam logic [7:0] ADDR_ALTERNATE_MERIT_ENABLE    = 8'h6e;
  localparam logic [7:0] ADDR_LINEAR_EQ_LOOK_BEYOND     = 8'h70;
  localparam logic [7:0] ADDR_FIRST_TAP_OBSERVE         = 8'h71;
  // ************************************************************
  // writable-bit masks (undefined bits read zero)
  // ************************************************************
  localparam logic [7:0] MASK_FEEDBACK_MERIT_SELECT  = 8'h3f;
  localparam logic [7:0] MASK_DRIVER_SWING           = 8'h07;
  localparam logic [7:0] MASK_RATE_LOCK_CONTROL      = 8'hff;
  localparam logic [7:0] MASK_EYE_INTERRUPT_STATUS   = 8'h0b;
  localparam logic [7:0] MASK_ADAPTATION_MODE_SELECT = 8'h78;
  localparam logic [7:0] MASK_FULL                   = 8'hff;
  localparam logic [7:0] MASK_UPPER_TAP_LIMIT        = 8'h0f;
  localparam logic [7:0] MASK_FIRST_TAP_LIMIT        = 8'h1f;
  localparam logic [7:0] MASK_REFCLK_INTERRUPT_CTRL  = 8'h77;
  localparam logic [7:0] MASK_LINEAR_EQ_START_INDEX  = 8'h1f;
  localparam logic [7:0] MASK_EYE_LOCK_MONITOR_EN    = 8'h80;
  localparam logic [7:0] MASK_ALTERNATE_MERIT_ENABLE = 8'hc0;
  localparam logic [7:0] MASK_LINEAR_EQ_LOOK_BEYOND  = 8'h07;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_FEEDBACK_MERIT_SELECT  = 8'h32;
  localparam logic [7:0] RST_DRIVER_SWING           = 8'h00;
  localparam logic [7:0] RST_RATE_LOCK_CONTROL      = 8'h06;
  localparam logic [7:0] RST_EYE_INTERRUPT_STATUS   = 8'h00;
  localparam logic [7:0] RST_ADAPTATION_MODE_SELECT = 8'h20;
  localparam logic [7:0] RST_EYE_INTERRUPT_THRESH   = 8'h11;
  localparam logic [7:0] RST_HANDOFF_EYE_THRESHOLD  = 8'h88;
  localparam logic [7:0] RST_UPPER_TAP_LIMIT        = 8'h0f;
  localparam logic [7:0] RST_FIRST_TAP_LIMIT        = 8'h1f;
  localparam logic [7:0] RST_REFCLK_INTERRUPT_CTRL  = 8'h31;
  localparam logic [7:0] RST_LINEAR_EQ_START_INDEX  = 8'h00;
  localparam logic [7:0] RST_LOW_RATE_FIXED_BOOST   = 8'ha5;
  localparam logic [7:0] RST_EYE_LOCK_MONITOR_EN    = 8'h80;
  localparam logic [7:0] RST_EYE_LOCK_THRESHOLD     = 8'h44;
  localparam logic [7:0] RST_MERIT_TERM             = 8'h00;
  localparam logic [7:0] RST_ALTERNATE_MERIT_ENABLE = 8'h00;
  localparam logic [7:0] RST_LINEAR_EQ_LOOK_BEYOND  = 8'h03;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_LINEAR_ADAPT_START = 0;
  localparam int BIT_FALSE_LOCK_OFF     = 1;
  localparam int BIT_FREQ_CHECK_ON      = 2;
  localparam int BIT_ADAPT_INDEX_OVR    = 3;
  localparam int BIT_EYE_FLAG           = 4;
  localparam int BIT_EYE_INT_ENABLE     = 6;
  localparam int BIT_VCO_RANGE_FORCE    = 2;
  localparam int BIT_EYE_LOCK_WATCH     = 7;
  localparam int BIT_ALT_MERIT_LINEAR   = 7;
  localparam int BIT_ALT_MERIT_FEEDBACK = 6;
  localparam int BIT_TAP1_POLARITY      = 5;
  // number of registers in the bank
  localparam int NUM_REGS = 19;
endpackage : ralc_pkg

/* rtl/ralc_regs.sv */
// channel control/status register bank with byte-wide access port
`timescale 1ns/1ns
`default_nettype none
module ralc_regs
  import ralc_pkg::*;
(
  input  wire logic       mclk,             // 10 MHz register clock
  input  wire logic       rst_b,            // synchronous reset, low
  input  wire logic       clk_en,           // freezes all state when low
  input  wire logic [7:0] reg_addr,         // register offset
  input  wire logic [7:0] reg_wdata,        // write data
  input  wire logic       reg_wr,           // write strobe
  input  wire logic       reg_rd,           // read strobe
  input  wire logic       eye_int_raw,      // eye-opening event (pin)
  input  wire logic       cdr_lock_lost,    // loss of lock event (pin)
  input  wire logic       signal_lost,      // loss of signal event (pin)
  input  wire logic [5:0] first_tap_live,   // applied tap 1 (pin)
  output logic      [7:0] reg_rdata,        // registered read data
  output logic            chan_int,         // channel interrupt request
  output logic            false_lock_on,    // false-lock detector active
  output logic            freq_check_on,    // frequency counter check on
  output logic            linear_adapt_go,  // adaptation start pulse
  output logic      [4:0] adapt_start_index,// effective start index
  output logic            adapt_index_override, // index override level
  output logic      [1:0] adapt_mode,       // adaptation mode
  output logic      [1:0] rate_sel,         // rate field
  output logic      [1:0] subrate_sel,      // sub-rate field
  output logic      [2:0] driver_amplitude, // driver swing
  output logic      [1:0] ref_clk_mode,     // reference clock mode
  output logic      [1:0] vco_bank_range,   // manual VCO bank range
  output logic            vco_bank_range_force, // range override
  output logic      [7:0] eye_int_thresholds, // {horiz, vert}
  output logic      [7:0] handoff_thresholds, // {horiz, vert}
  output logic      [3:0] upper_tap_max,    // taps 2-5 limit
  output logic      [4:0] first_tap_max,    // tap 1 limit
  output logic      [7:0] low_rate_stage_boost, // stages 0..3
  output logic            eye_lock_watch_on,// eye lock monitor enable
  output logic      [7:0] eye_lock_thresholds, // {vert, horiz}
  output logic      [1:0] feedback_merit_kind, // feedback merit type
  output logic      [1:0] linear_merit_kind,   // linear merit type
  output logic      [3:0] feedback_lookahead,  // feedback look-beyond
  output logic      [2:0] linear_lookahead_count, // linear look-beyond
  output logic      [1:0] alt_merit_enable, // {linear, feedback}
  output logic     [23:0] merit_terms       // {a, b, c}
);

  // ************************************************************
  // register storage and address table
  // ************************************************************
  logic [7:0] regs [NUM_REGS];            // writable register images

  // table of offsets, masks and reset values, index order
  localparam logic [7:0] OFFS [NUM_REGS] = '{
    ADDR_FEEDBACK_MERIT_SELECT, ADDR_DRIVER_SWING,
    ADDR_RATE_LOCK_CONTROL, ADDR_EYE_INTERRUPT_STATUS,
    ADDR_ADAPTATION_MODE_SELECT, ADDR_EYE_INTERRUPT_THRESHOLD,
    ADDR_HANDOFF_EYE_THRESHOLD, ADDR_UPPER_TAP_LIMIT,
    ADDR_FIRST_TAP_LIMIT, ADDR_REFCLK_INTERRUPT_CONTROL,
    ADDR_LINEAR_EQ_START_INDEX, ADDR_LOW_RATE_FIXED_BOOST,
    ADDR_EYE_LOCK_MONITOR_ENABLE, ADDR_EYE_LOCK_THRESHOLD,
    ADDR_MERIT_TERM_A, ADDR_MERIT_TERM_B, ADDR_MERIT_TERM_C,
    ADDR_ALTERNATE_MERIT_ENABLE, ADDR_LINEAR_EQ_LOOK_BEYOND};
  localparam logic [7:0] MASKS [NUM_REGS] = '{
    MASK_FEEDBACK_MERIT_SELECT, MASK_DRIVER_SWING,
    MASK_RATE_LOCK_CONTROL, MASK_EYE_INTERRUPT_STATUS,
    MASK_ADAPTATION_MODE_SELECT, MASK_FULL, MASK_FULL,
    MASK_UPPER_TAP_LIMIT, MASK_FIRST_TAP_LIMIT,
    MASK_REFCLK_INTERRUPT_CTRL, MASK_LINEAR_EQ_START_INDEX,
    MASK_FULL, MASK_EYE_LOCK_MONITOR_EN, MASK_FULL, MASK_FULL,
    MASK_FULL, MASK_FULL, MASK_ALTERNATE_MERIT_ENABLE,
    MASK_LINEAR_EQ_LOOK_BEYOND};
  localparam logic [7:0] RSTV [NUM_REGS] = '{
    RST_FEEDBACK_MERIT_SELECT, RST_DRIVER_SWING,
    RST_RATE_LOCK_CONTROL, RST_EYE_INTERRUPT_STATUS,
    RST_ADAPTATION_MODE_SELECT, RST_EYE_INTERRUPT_THRESH,
    RST_HANDOFF_EYE_THRESHOLD, RST_UPPER_TAP_LIMIT,
    RST_FIRST_TAP_LIMIT, RST_REFCLK_INTERRUPT_CTRL,
    RST_LINEAR_EQ_START_INDEX, RST_LOW_RATE_FIXED_BOOST,
    RST_EYE_LOCK_MONITOR_EN, RST_EYE_LOCK_THRESHOLD,
    RST_MERIT_TERM, RST_MERIT_TERM, RST_MERIT_TERM,
    RST_ALTERNATE_MERIT_ENABLE, RST_LINEAR_EQ_LOOK_BEYOND};

  // index positions of registers with side effects
  localparam int IX_RLC = 2;   // rate/lock control
  localparam int IX_EIS = 3;   // eye interrupt status
  localparam int IX_RIC = 9;   // refclk/interrupt control

  // ************************************************************
  // pin input synchronisers (three stages, 2nd/3rd agree)
  // ************************************************************
  logic [8:0] sync1;      // first stage, feeds only sync2
  logic [8:0] sync2;      // second stage
  logic [8:0] sync3;      // third stage
  logic [8:0] pin_state;  // filtered value
  wire  [8:0] pin_raw = {eye_int_raw, cdr_lock_lost, signal_lost,
                         first_tap_live};

  // sample pins; accept new value only when two stages agree
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sync1     <= 9'h000;
      sync2     <= 9'h000;
      sync3     <= 9'h000;
      pin_state <= 9'h000;
    end
    else if (clk_en)
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      // event pins settle bit by bit
      for (int i = 6; i < 9; i++)
        if (sync2[i] == sync3[i])
          pin_state[i] <= sync2[i];
      // the tap word moves only as a whole, so a read never shows a
      // weight from one sample next to a polarity from another
      if (sync2[5:0] == sync3[5:0])
        pin_state[5:0] <= sync2[5:0];
    end
  end

  // ************************************************************
  // decode
  // ************************************************************
  // one-hot match of an offset against the table
  function automatic logic [NUM_REGS-1:0] match(input logic [7:0] a);
    logic [NUM_REGS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_REGS; i++)
      m[i] = (a == OFFS[i]);
    return m;
  endfunction

  wire [NUM_REGS-1:0] hit       = match(reg_addr);
  wire                hit_obs   = (reg_addr == ADDR_FIRST_TAP_OBSERVE);
  wire                eye_prev_w;
  logic               eye_prev;        // edge detect on filtered event
  assign eye_prev_w = pin_state[8];
  wire eye_rise  = eye_prev_w & ~eye_prev;
  wire eye_allow = regs[IX_RIC][BIT_EYE_INT_ENABLE];
  wire eye_set   = eye_rise & eye_allow;
  wire eye_clr   = reg_rd & hit[IX_EIS];

  // read mux; unmapped offsets and undefined bits read zero
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    for (int i = 0; i < NUM_REGS; i++)
      if (hit[i])
        next_rdata = regs[i] & MASKS[i];
    if (hit[IX_EIS])
      next_rdata[BIT_EYE_FLAG] = regs[IX_EIS][BIT_EYE_FLAG];
    if (hit_obs)
      next_rdata = {2'b00, pin_state[5:0]};
  end

  // ************************************************************
  // register file; writes honour masks, status flag set wins
  // ************************************************************
  generate
    for (genvar g = 0; g < NUM_REGS; g++)
    begin : g_reg
      // one byte; status keeps its hardware-set flag separately
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
          regs[g] <= RSTV[g];
        else if (clk_en)
        begin
          if (g == IX_EIS)
          begin
            // factory bits stay writable; flag is read-only
            if (reg_wr && hit[g])
              regs[g][3:0] <= reg_wdata[3:0] & MASKS[g][3:0];
            if (eye_set)
              regs[g][BIT_EYE_FLAG] <= 1'b1;
            else if (eye_clr)
              regs[g][BIT_EYE_FLAG] <= 1'b0;
          end
          else if (g == IX_RLC && !(reg_wr && hit[g]))
            regs[g][BIT_LINEAR_ADAPT_START] <= 1'b0;      // self-clear
          else if (reg_wr && hit[g])
            regs[g] <= reg_wdata & MASKS[g];
        end
      end
    end
  endgenerate

  // ************************************************************
  // outputs, all registered
  // ************************************************************
  // interrupt: lock or signal loss always, eye only when enabled
  wire next_int = pin_state[7] | pin_state[6]
                | regs[IX_EIS][BIT_EYE_FLAG];

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 8'h00;
      chan_int  <= 1'b0;
      eye_prev  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (reg_rd)
        reg_rdata <= next_rdata;
      chan_int <= next_int;
      eye_prev <= eye_prev_w;
    end
  end

  // control fields copied to flops; one cycle after the write
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      false_lock_on          <= 1'b0;
      freq_check_on          <= 1'b1;
      linear_adapt_go        <= 1'b0;
      adapt_start_index      <= 5'h00;
      adapt_index_override   <= 1'b0;
      adapt_mode             <= 2'h1;
      rate_sel               <= 2'h0;
      subrate_sel            <= 2'h0;
      driver_amplitude       <= 3'h0;
      ref_clk_mode           <= 2'h3;
      vco_bank_range         <= 2'h1;
      vco_bank_range_force   <= 1'b0;
      eye_int_thresholds     <= RST_EYE_INTERRUPT_THRESH;
      handoff_thresholds     <= RST_HANDOFF_EYE_THRESHOLD;
      upper_tap_max          <= 4'hf;
      first_tap_max          <= 5'h1f;
      low_rate_stage_boost   <= RST_LOW_RATE_FIXED_BOOST;
      eye_lock_watch_on      <= 1'b1;
      eye_lock_thresholds    <= RST_EYE_LOCK_THRESHOLD;
      feedback_merit_kind    <= 2'h3;
      linear_merit_kind      <= 2'h0;
      feedback_lookahead     <= 4'h2;
      linear_lookahead_count <= 3'h3;
      alt_merit_enable       <= 2'h0;
      merit_terms            <= 24'h000000;
    end
    else if (clk_en)
    begin
      false_lock_on   <= ~regs[IX_RLC][BIT_FALSE_LOCK_OFF];
      freq_check_on   <= regs[IX_RLC][BIT_FREQ_CHECK_ON];
      linear_adapt_go <= regs[IX_RLC][BIT_LINEAR_ADAPT_START];
      adapt_index_override <= regs[IX_RLC][BIT_ADAPT_INDEX_OVR];
      adapt_start_index <= regs[IX_RLC][BIT_ADAPT_INDEX_OVR]
                         ? regs[10][4:0] : 5'h00;
      rate_sel        <= regs[IX_RLC][7:6];
      subrate_sel     <= regs[IX_RLC][5:4];
      driver_amplitude <= regs[1][2:0];
      adapt_mode      <= regs[4][6:5];
      linear_merit_kind <= regs[4][4:3];
      eye_int_thresholds <= regs[5];
      handoff_thresholds <= regs[6];
      upper_tap_max   <= regs[7][3:0];
      first_tap_max   <= regs[8][4:0];
      ref_clk_mode    <= regs[IX_RIC][5:4];
      vco_bank_range  <= regs[IX_RIC][1:0];
      vco_bank_range_force <= regs[IX_RIC][BIT_VCO_RANGE_FORCE];
      low_rate_stage_boost <= regs[11];
      eye_lock_watch_on <= regs[12][BIT_EYE_LOCK_WATCH];
      eye_lock_thresholds <= regs[13];
      merit_terms     <= {regs[14], regs[15], regs[16]};
      alt_merit_enable <= {regs[17][BIT_ALT_MERIT_LINEAR],
                           regs[17][BIT_ALT_MERIT_FEEDBACK]};
      feedback_merit_kind <= regs[0][5:4];
      feedback_lookahead <= regs[0][3:0];
      linear_lookahead_count <= regs[18][2:0];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  // a status read drops the eye flag unless a new event lands with it
  a_eye_flag_clear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && eye_clr && !eye_set |=> !regs[IX_EIS][BIT_EYE_FLAG])
    else $error("eye flag not cleared by status read");
  // set beats clear, so an event in the read cycle is never lost
  a_eye_set_wins: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && eye_set |=> regs[IX_EIS][BIT_EYE_FLAG])
    else $error("eye event did not set the flag");
  // with the enable off, a clear flag stays clear
  a_eye_gate_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !eye_allow && !regs[IX_EIS][BIT_EYE_FLAG]
    |=> !regs[IX_EIS][BIT_EYE_FLAG])
    else $error("eye flag set while disabled");
  // software writes never reach the flag bit
  a_flag_read_only: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && reg_wr && hit[IX_EIS] && !eye_set && !eye_clr
    |=> $stable(regs[IX_EIS][BIT_EYE_FLAG]))
    else $error("status flag changed by a write");
  // loss of lock interrupts whatever the eye enable says
  a_loss_int: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && pin_state[7] |=> chan_int)
    else $error("loss of lock did not interrupt");
  // loss of signal interrupts the same way
  a_signal_int: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && pin_state[6] |=> chan_int)
    else $error("loss of signal did not interrupt");
  // with no cause left the request must drop
  a_int_quiet: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && !pin_state[7] && !pin_state[6]
    && !regs[IX_EIS][BIT_EYE_FLAG] |=> !chan_int)
    else $error("interrupt raised with no cause");
  // one start write gives one pulse; a rewrite next cycle is excluded
  a_go_pulse: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && reg_wr && hit[IX_RLC] && reg_wdata[BIT_LINEAR_ADAPT_START]
    ##1 clk_en && !(reg_wr && hit[IX_RLC]) ##1 clk_en
    |-> linear_adapt_go ##1 (!linear_adapt_go || !clk_en))
    else $error("adaptation start not a single pulse");
  // the start bit falls back by itself one cycle after it is written
  a_start_drop: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && regs[IX_RLC][BIT_LINEAR_ADAPT_START]
    && !(reg_wr && hit[IX_RLC])
    |=> !regs[IX_RLC][BIT_LINEAR_ADAPT_START])
    else $error("adaptation start bit did not self-clear");
  // the detector bit is inverted: one keeps the detector off
  a_false_lock: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en |=> false_lock_on == !$past(regs[IX_RLC][BIT_FALSE_LOCK_OFF]))
    else $error("false-lock enable wrong polarity");
  // frequency check follows its bit with one cycle of delay
  a_freq_check: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en |=> freq_check_on == $past(regs[IX_RLC][BIT_FREQ_CHECK_ON]))
    else $error("frequency check enable mismatch");
  // without the override the start index is held at zero
  a_index_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && !regs[IX_RLC][BIT_ADAPT_INDEX_OVR]
    |=> adapt_start_index == 5'h00)
    else $error("start index used without override");
  // with the override the stored index goes out unchanged
  a_index_used: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && regs[IX_RLC][BIT_ADAPT_INDEX_OVR]
    |=> adapt_start_index == $past(regs[10][4:0]))
    else $error("start index lost under override");
  // offsets outside the bank read back as zero
  a_unmapped_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && reg_rd && !(|hit) && !hit_obs |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // undefined upper bits of the swing byte read as zero
  a_swing_upper: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && reg_rd && hit[1] |=> reg_rdata[7:3] == 5'h00)
    else $error("undefined swing bits not zero");
  // observation byte shows the filtered tap word, upper bits zero
  a_tap_view: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clk_en && reg_rd && hit_obs
    |=> reg_rdata == {2'b00, $past(pin_state[5:0])})
    else $error("tap observe value wrong");

endmodule // ralc_regs
`default_nettype wire

/* tb/ralc_host.sv */
// system controller model driving the byte-wide register port
`timescale 1ns/1ns
`default_nettype none
module ralc_host
(
  input  wire logic       mclk,      // register clock
  input  wire logic [7:0] reg_rdata, // read data from the bank
  output logic      [7:0] reg_addr,  // register offset
  output logic      [7:0] reg_wdata, // write data
  output logic            reg_wr,    // write strobe
  output logic            reg_rd     // read strobe
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
  // one write; the factory fields of the status byte always stay zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = (a == 8'h30) ? (d & 8'hf4) : d;
    reg_wr = 1'b1;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a; // stale bus: never leave the old value showing
    reg_wdata = ~d;
  endtask
  // one read; data is picked up an edge after the read is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge mclk) #1;
    d = reg_rdata;
  endtask
endmodule // ralc_host
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the channel register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       mclk = 1'b0;   // 10 MHz clock
  logic       en = 1'b1;     // clock enable
  logic       rst_b = 1'b0;  // reset, low
  logic       eye_int_raw = 1'b0, cdr_lock_lost = 1'b0, signal_lost = 1'b0;
  logic [5:0] live = 6'h00;  // applied tap 1
  wire  logic [7:0] addr, wdata, rdata;
  wire  logic       wr, rd, go, chan_int;
  wire  logic [100:0] o;     // registered control outputs, packed
  logic [7:0] m [256];       // register image
  logic [7:0] wm [256];      // writable bits per offset
  logic [7:0] rv;            // last read value
  int err_total = 0, checks_done = 0, n;
  // offset, reset value, writable mask
  localparam logic [23:0] REGS [20] = '{
    24'h2c323f, 24'h2d0007, 24'h2f06ff, 24'h300000,
    24'h312078, 24'h3211ff, 24'h3388ff, 24'h340f0f,
    24'h351f1f, 24'h363177, 24'h39001f, 24'h3aa5ff,
    24'h3e8080, 24'h6a44ff, 24'h6b00ff, 24'h6c00ff,
    24'h6d00ff, 24'h6e00c0, 24'h700307, 24'h710000};
  always #50 mclk = ~mclk;
  ralc_host ralc_host_i (.mclk(mclk), .reg_rdata(rdata), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  ralc_regs ralc_regs_i (.mclk(mclk), .rst_b(rst_b), .clk_en(en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .eye_int_raw(eye_int_raw), .cdr_lock_lost(cdr_lock_lost),
    .signal_lost(signal_lost), .first_tap_live(live), .reg_rdata(rdata),
    .chan_int(chan_int), .false_lock_on(o[100]), .freq_check_on(o[99]),
    .linear_adapt_go(go), .adapt_start_index(o[97:93]),
    .adapt_index_override(o[98]), .adapt_mode(o[92:91]),
    .rate_sel(o[90:89]), .subrate_sel(o[88:87]),
    .driver_amplitude(o[86:84]), .ref_clk_mode(o[83:82]),
    .vco_bank_range(o[81:80]), .vco_bank_range_force(o[79]),
    .eye_int_thresholds(o[78:71]), .handoff_thresholds(o[70:63]),
    .upper_tap_max(o[62:59]), .first_tap_max(o[58:54]),
    .low_rate_stage_boost(o[53:46]), .eye_lock_watch_on(o[45]),
    .eye_lock_thresholds(o[44:37]), .feedback_merit_kind(o[36:35]),
    .linear_merit_kind(o[34:33]), .feedback_lookahead(o[32:29]),
    .linear_lookahead_count(o[28:26]), .alt_merit_enable(o[25:24]),
    .merit_terms(o[23:0]));
  // compare and count; four-state equality so an unknown matches only the same unknown in exp
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // bus write plus image update; start bit falls back by itself
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    ralc_host_i.wr(a, d);
    m[a] = (m[a] & ~wm[a]) | (d & wm[a]);
    if (a == 8'h2f) m[a][0] = 1'b0;
  endtask
  task automatic mrd(input logic [7:0] a, input logic [7:0] x);
    ralc_host_i.rd(a, rv);
    chk(rv, x);
  endtask
  // control outputs as the image says they must be
  function automatic logic [100:0] eo();
    eo = {~m[8'h2f][1], m[8'h2f][2], m[8'h2f][3],
      m[8'h2f][3] ? m[8'h39][4:0] : 5'h00, m[8'h31][6:5], m[8'h2f][7:4],
      m[8'h2d][2:0], m[8'h36][5:4], m[8'h36][1:0], m[8'h36][2], m[8'h32],
      m[8'h33], m[8'h34][3:0], m[8'h35][4:0], m[8'h3a], m[8'h3e][7],
      m[8'h6a], m[8'h2c][5:4], m[8'h31][4:3], m[8'h2c][3:0], m[8'h70][2:0],
      m[8'h6e][7:6], m[8'h6b], m[8'h6c], m[8'h6d]};
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    n = $urandom(90);
    foreach (m[i]) {m[i], wm[i]} = 16'h0000;
    foreach (REGS[i]) {m[REGS[i][23:16]], wm[REGS[i][23:16]]} = REGS[i][15:0];
    repeat (8) @(posedge mclk);
    #1 rst_b = 1'b1;
    chk(o, eo());
    for (int a = 0; a < 256; a++) mrd(a[7:0], m[a]);
    repeat (2)
    begin
      live = 6'($urandom);
      for (int a = 0; a < 256; a++) mwr(a[7:0], 8'($urandom));
      repeat (3) @(posedge mclk);
      #1 chk(o, eo());
      for (int a = 0; a < 256; a++)
        mrd(a[7:0], a == 8'h71 ? {2'b00, live} : m[a]);
    end
    mwr(8'h2f, m[8'h2f] | 8'h01);
    n = 0;
    repeat (5) @(posedge mclk) #1 n += go;
    chk(n, 1);
    en = 1'b0; // a frozen bank ignores the bus and holds every output
    ralc_host_i.wr(8'h2d, ~m[8'h2d]);
    en = 1'b1;
    chk(o, eo());
    mrd(8'h2d, m[8'h2d]);
    for (int e = 1; e >= 0; e--)
    begin
      mwr(8'h36, {m[8'h36][7], e[0], m[8'h36][5:0]});
      repeat (3) @(posedge mclk);
      #1 eye_int_raw = 1'b1;
      repeat (8) @(posedge mclk);
      #1 eye_int_raw = 1'b0;
      chk(chan_int, e[0]);
      mrd(8'h30, {3'b000, e[0], 4'h0});
      mrd(8'h30, 8'h00);
      chk(chan_int, 1'b0);
    end
    for (int k = 1; k < 4; k++)
    begin
      {cdr_lock_lost, signal_lost} = k[1:0];
      repeat (6) @(posedge mclk);
      #1 chk(chan_int, 1'b1);
      {cdr_lock_lost, signal_lost} = 2'b00;
      repeat (6) @(posedge mclk);
      #1 chk(chan_int, 1'b0);
    end
    rst_b = 1'b0; // reset in mid-run brings every default back
    @(posedge mclk) #1 rst_b = 1'b1;
    foreach (REGS[i]) m[REGS[i][23:16]] = REGS[i][15:8];
    chk(o, eo());
    mrd(8'h2f, m[8'h2f]);
    conclude();
  end
  // hang guard, well past the expected run of a few thousand cycles
  initial
  begin
    #2000000;
    err_total++;
    conclude();
  end
endmodule // tb
`default_nettype wire
